// *** hw/tick_if.sv ***
// timebase tick carried from the divider to the watchdog core
`timescale 1ns/1ps
`default_nettype none

interface tick_if;
  logic tick;

  modport src  (output tick);
  modport sink (input  tick);
endinterface

`default_nettype wire

// *** hw/wdog_defs.svh ***
// constants for the window watchdog: times, counts and widths
// How it works
// RULE1: time between heartbeat rising edges; fault when outside the window.
// RULE2: interval below fast timeout is a fast fault, above slow timeout a slow fault.
// RULE3: fast timeout is one eighth of the slow timeout.
// RULE4: window resistor in kilohms equals 3.24 times slow timeout in ms.
// RULE5: any fault pulls reset output low for the fault pulse time, then releases.
// RULE6: monitoring only while the enable input is low; high means no faults.
// RULE7: monitoring waits until both rails stayed good for the activation delay.
// RULE8: no edge within activation delay plus slow timeout gives a pulse and clear.
// RULE9: the missing-heartbeat fault and restart repeats until edges return.
// RULE10: host drives heartbeat edges spaced between fast and slow timeouts.
// RULE11: timeouts are parameters measured against an internal timebase counter.
// RULE12: disabled or starting: counters held clear and reset output not driven; while starting the counter times the activation delay.
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH

`define WDOG_CLK_NS        8
`define WDOG_TICK_NS       1000
`define WDOG_TICK_CYCLES   ((`WDOG_TICK_NS) / (`WDOG_CLK_NS))
`define WDOG_DIV_W         8
`define WDOG_CNT_W         24
`define WDOG_FAULT_US      2000
`define WDOG_START_US      30000
`define WDOG_RESISTOR_OHM  32400
`define WDOG_RES_NUM       100
`define WDOG_RES_DEN       324
`define WDOG_FAST_DIV      8

`endif

// *** hw/wdog_pkg.sv ***
// types shared by the watchdog modules
`default_nettype none
`include "wdog_defs.svh"

package wdog_pkg;

  // watchdog sequencer, one-hot
  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_START = 4'h2,
    ST_RUN   = 4'h4,
    ST_FAULT = 4'h8
  } wdog_state_t;

  // all state of the watchdog core
  typedef struct packed {
    wdog_state_t            st;
    logic [`WDOG_CNT_W-1:0] cnt;
    logic                   seen;
    logic [1:0]             hb_s;
    logic                   hb_d;
    logic [1:0]             en_s;
    logic [1:0]             r1_s;
    logic [1:0]             r2_s;
    logic                   fast_r;
    logic                   slow_r;
  } wdog_regs_t;

  // all state of the timebase
  typedef struct packed {
    logic [`WDOG_DIV_W-1:0] div;
    logic                   tick;
  } tb_regs_t;

endpackage

`default_nettype wire

// *** hw/wdog_timebase.sv ***
// divider that makes one tick pulse per timebase period
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.svh"

module wdog_timebase
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // tick out
  tick_if.src       tb
);

  localparam logic [`WDOG_DIV_W-1:0] LAST = `WDOG_DIV_W'(`WDOG_TICK_CYCLES - 1);

  wdog_pkg::tb_regs_t r;
  wdog_pkg::tb_regs_t n;

  // free-running divider, tick on wrap
  always_comb
  begin
    n      = r;
    n.tick = (r.div == LAST);
    n.div  = (r.div == LAST) ? '0 : r.div + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign tb.tick = r.tick;

  // tick is never repeated in the two cycles after a tick
  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    r.tick |=> !r.tick [*2]) // RULE11
    else $error("timebase tick repeated too soon");

endmodule

`default_nettype wire

// *** hw/window_watchdog_timer.sv ***
// window watchdog core: heartbeat interval check and reset pulse
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.svh"

module window_watchdog_timer
#(
  parameter int WINDOW_RESISTOR_OHM = `WDOG_RESISTOR_OHM,
  parameter int START_US            = `WDOG_START_US,
  parameter int FAULT_US            = `WDOG_FAULT_US
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // host heartbeat and enable pins
  input  wire logic heartbeat_clock_in,
  input  wire logic wdog_enable_n,
  // rail good indications
  input  wire logic first_regulator_rail,
  input  wire logic second_regulator_rail,
  // open-drain reset pin
  output logic      reset_out_n_o,
  output logic      reset_out_n_oe,
  // status
  output logic      wdog_fault_flag,
  output logic      fast_fault,
  output logic      slow_fault,
  output logic      wdog_active
);

  // timeouts in microseconds, slow one from the resistor value
  localparam int SLOW_US = WINDOW_RESISTOR_OHM * `WDOG_RES_NUM / `WDOG_RES_DEN; // RULE4
  localparam int FAST_US = SLOW_US / `WDOG_FAST_DIV; // RULE3

  // the same times counted in timebase ticks
  localparam logic [`WDOG_CNT_W-1:0] SLOW_TK  =
    `WDOG_CNT_W'(SLOW_US * 1000 / `WDOG_TICK_NS); // RULE11
  localparam logic [`WDOG_CNT_W-1:0] FAST_TK  =
    `WDOG_CNT_W'(FAST_US * 1000 / `WDOG_TICK_NS); // RULE11
  localparam logic [`WDOG_CNT_W-1:0] START_TK =
    `WDOG_CNT_W'(START_US * 1000 / `WDOG_TICK_NS);
  localparam logic [`WDOG_CNT_W-1:0] FAULT_TK =
    `WDOG_CNT_W'(FAULT_US * 1000 / `WDOG_TICK_NS);

  wdog_pkg::wdog_regs_t r;
  wdog_pkg::wdog_regs_t n;

  logic                   rise;
  logic                   armed;
  logic [`WDOG_CNT_W-1:0] cnt_inc;

  tick_if tb ();

  // microsecond timebase
  wdog_timebase u_timebase
  (
    .clk (clk),
    .rst (rst),
    .tb  (tb.src)
  );

  // edge and arming terms from the second synchroniser stage only
  assign rise    = r.hb_s[1] & ~r.hb_d;
  assign armed   = ~r.en_s[1] & r.r1_s[1] & r.r2_s[1];
  assign cnt_inc = (tb.tick && (r.cnt != '1)) ? r.cnt + 1'b1 : r.cnt;

  // next-state logic of the whole core
  always_comb
  begin
    n        = r;
    n.hb_s   = {r.hb_s[0], heartbeat_clock_in};
    n.hb_d   = r.hb_s[1];
    n.en_s   = {r.en_s[0], wdog_enable_n};
    n.r1_s   = {r.r1_s[0], first_regulator_rail};
    n.r2_s   = {r.r2_s[0], second_regulator_rail};
    n.fast_r = 1'b0;
    n.slow_r = 1'b0;

    unique case (r.st)
      wdog_pkg::ST_OFF:
      begin
        n.cnt  = '0; // RULE12
        n.seen = 1'b0;
        n.st   = wdog_pkg::ST_START;
      end

      // activation delay: rails must stay good throughout
      wdog_pkg::ST_START:
      begin
        n.cnt  = cnt_inc;
        n.seen = 1'b0;
        if (cnt_inc >= START_TK) // RULE7
        begin
          n.st  = wdog_pkg::ST_RUN;
          n.cnt = '0;
        end
      end

      // window monitoring of heartbeat rising edges
      wdog_pkg::ST_RUN:
      begin
        n.cnt = cnt_inc; // RULE1
        if (rise)
        begin
          if (r.seen && (r.cnt < FAST_TK)) // RULE2
          begin
            n.fast_r = 1'b1;
            n.st     = wdog_pkg::ST_FAULT;
            n.cnt    = '0;
          end
          else
          begin
            n.cnt  = '0;
            n.seen = 1'b1;
          end
        end
        else if (cnt_inc >= SLOW_TK) // RULE2 RULE8
        begin
          n.slow_r = 1'b1;
          n.st     = wdog_pkg::ST_FAULT;
          n.cnt    = '0;
        end
      end

      // reset pulse, then restart through the activation delay
      wdog_pkg::ST_FAULT:
      begin
        n.cnt = cnt_inc;
        if (cnt_inc >= FAULT_TK) // RULE5
        begin
          n.st   = wdog_pkg::ST_START; // RULE9
          n.cnt  = '0;
          n.seen = 1'b0;
        end
      end
    endcase

    // disable or bad rail drops everything at once
    if (!armed) // RULE6 RULE12
    begin
      n.st   = wdog_pkg::ST_OFF;
      n.cnt  = '0;
      n.seen = 1'b0;
    end
  end

  // register the whole state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r      <= '0;
      r.st   <= wdog_pkg::ST_OFF;
      r.en_s <= 2'h3;
    end
    else
      r <= n;
  end

  // outputs straight from state flops
  assign reset_out_n_o   = 1'b0;
  assign reset_out_n_oe  = (r.st == wdog_pkg::ST_FAULT); // RULE5
  assign wdog_fault_flag = (r.st == wdog_pkg::ST_FAULT);
  assign fast_fault      = r.fast_r;
  assign slow_fault      = r.slow_r;
  assign wdog_active     = (r.st == wdog_pkg::ST_RUN);

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_fault_enter;
    (r.st != wdog_pkg::ST_FAULT) ##1 (r.st == wdog_pkg::ST_FAULT);
  endsequence

  sequence s_fault_done;
    (r.st == wdog_pkg::ST_FAULT) && tb.tick && (r.cnt == FAULT_TK - 1'b1) && armed;
  endsequence

  sequence s_start_done;
    (r.st == wdog_pkg::ST_START) && tb.tick && (r.cnt == START_TK - 1'b1) && armed;
  endsequence

  a_pin_follows_fault: assert property ( // RULE5
    reset_out_n_oe == (r.st == wdog_pkg::ST_FAULT) && !(reset_out_n_oe && reset_out_n_o))
    else $error("reset pin drive does not match fault state");

  a_fault_ends_release: assert property ( // RULE5
    s_fault_done |=> (r.st == wdog_pkg::ST_START) && !reset_out_n_oe ##1 !reset_out_n_oe)
    else $error("fault pulse did not end on time");

  a_fault_needs_arm: assert property ( // RULE6
    s_fault_enter |-> $past(armed) && $past(r.st == wdog_pkg::ST_RUN, 1))
    else $error("fault raised while not monitoring");

  a_disable_clears: assert property ( // RULE12
    !armed |=> (r.st == wdog_pkg::ST_OFF) && (r.cnt == '0) && !reset_out_n_oe)
    else $error("disable did not clear the watchdog");

  a_start_to_run: assert property ( // RULE7
    s_start_done |=> (r.st == wdog_pkg::ST_RUN) && (r.cnt == '0))
    else $error("activation delay did not hand over to monitoring");

  a_fast_class: assert property ( // RULE2
    $rose(r.fast_r) |-> $past(rise) && $past(r.seen) && ($past(r.cnt) < FAST_TK))
    else $error("fast fault without a short interval");

  a_slow_class: assert property ( // RULE2
    $rose(r.slow_r) |-> ($past(cnt_inc) >= SLOW_TK) && !$past(rise))
    else $error("slow fault without a long interval");

  a_missing_restart: assert property ( // RULE8
    r.slow_r && !r.seen |-> (r.st == wdog_pkg::ST_FAULT) && (r.cnt == '0))
    else $error("missing heartbeat did not clear counters");

  a_good_edge_clears: assert property ( // RULE1
    (r.st == wdog_pkg::ST_RUN) && rise && armed && !(r.seen && r.cnt < FAST_TK)
      |=> (r.cnt == '0) && r.seen && (r.st == wdog_pkg::ST_RUN))
    else $error("valid heartbeat edge did not restart the interval");

  a_window_ratio: assert property ( // RULE3
    FAST_TK == `WDOG_CNT_W'(SLOW_US / `WDOG_FAST_DIV * 1000 / `WDOG_TICK_NS))
    else $error("fast timeout is not one eighth of slow timeout");

endmodule

`default_nettype wire

// *** testbench/host_heartbeat.sv ***
// host model: heartbeat clock with settable period
`timescale 1ns/1ps
`default_nettype none
module host_heartbeat
(
  // clock
  input  wire logic        clk,
  // control
  input  wire logic        run,
  input  wire logic [15:0] period,
  // heartbeat pin
  output logic             hb
);
  logic [15:0] cnt_r;
  // one rising edge per period, held low when stopped
  always_ff @(posedge clk)
  begin
    if (!run || cnt_r >= period - 16'h0001)
    begin
      cnt_r <= 16'h0000;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
    end
    hb <= run && (cnt_r < (period >> 1));
  end
endmodule
`default_nettype wire

// *** testbench/window_watchdog_timer_tb.sv ***
// self-checking bench for the window watchdog
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_timer_tb;
  logic        clk, rst, en_n, r1, r2, run, hb, o, oe, flag, ff, sf, act, pin_q, act_q;
  logic [15:0] period;
  wire logic   pin = oe ? o : 1'h1; // pull-up on the reset pin
  int          errors, samples_checked, cyc, oe_run, oe_len, oe_n, fast_n, slow_n;
  int          slow_t, slow_p, act_t;

  window_watchdog_timer #(.WINDOW_RESISTOR_OHM(324), .START_US(50), .FAULT_US(20)) DUT (
    .clk(clk), .rst(rst), .heartbeat_clock_in(hb), .wdog_enable_n(en_n),
    .first_regulator_rail(r1), .second_regulator_rail(r2), .reset_out_n_o(o),
    .reset_out_n_oe(oe), .wdog_fault_flag(flag), .fast_fault(ff), .slow_fault(sf),
    .wdog_active(act));
  host_heartbeat host (.clk(clk), .run(run), .period(period), .hb(hb));

  // clock
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // event counters and pulse timing
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    pin_q <= pin;
    act_q <= act;
    if (!pin) oe_run <= oe_run + 1;
    else if (oe_run != 0)
    begin
      oe_len <= oe_run;
      oe_run <= 0;
    end
    if (pin_q && !pin) oe_n <= oe_n + 1;
    if (ff === 1'h1) fast_n <= fast_n + 1;
    if (sf === 1'h1)
    begin
      slow_n <= slow_n + 1;
      slow_t <= cyc;
      slow_p <= slow_t;
    end
    if (act && !act_q) act_t <= cyc;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
  endfunction

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_disabled();
    en_n <= 1'h1;
    cycles(20000);
    chk("fault count", 0, oe_n);
    chk("active", 0, {31'h0, act});
    $display("test disabled done");
  endtask

  task automatic t_start();
    en_n <= 1'h0;
    cycles(6000);
    chk("active early", 0, {31'h0, act});
    cycles(500);
    chk("active", 1, {31'h0, act});
    period <= 16'h1388;
    run <= 1'h1;
    cycles(15000);
    chk("faults in window", 0, oe_n);
    $display("test start done");
  endtask

  task automatic t_fast();
    period <= 16'h0271;
    for (int i = 0; i < 3000 && fast_n == 0; i++) @(posedge clk);
    chk("fault flag", 1, {31'h0, flag});
    run <= 1'h0;
    for (int i = 0; i < 3000 && !pin; i++) @(posedge clk);
    cycles(2);
    chk("fault flag off", 0, {31'h0, flag});
    chk("fast count", 1, fast_n);
    chk("slow count", 0, slow_n);
    chk("pulse length", 1, inr(oe_len, 2375, 2625));
    $display("test fast done");
  endtask

  task automatic t_missing();
    for (int i = 0; i < 50000 && slow_n < 2; i++) @(posedge clk);
    cycles(1);
    chk("slow count", 2, slow_n);
    chk("pulse count", 3, oe_n);
    chk("slow fault flag", 1, {31'h0, flag});
    chk("slow delay", 1, inr(slow_t - act_t, 12350, 12650));
    chk("repeat gap", 1, inr(slow_t - slow_p, 20850, 21650));
    $display("test missing done");
  endtask

  task automatic t_rail();
    r1 <= 1'h0;
    cycles(6);
    chk("pin released", 1, {31'h0, pin});
    r1 <= 1'h1;
    cycles(6000);
    chk("active restart", 0, {31'h0, act});
    $display("test rail done");
  endtask

  // main sequence
  initial
  begin
    rst = 1'h1;
    en_n = 1'h1;
    r1 = 1'h1;
    r2 = 1'h1;
    run = 1'h0;
    period = 16'h1388;
    cycles(3);
    rst <= 1'h0;
    t_disabled();
    t_start();
    t_fast();
    t_missing();
    t_rail();
    final_report();
  end

  // watchdog against a hang
  initial
  begin
    cycles(100000);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
